// file: hdl/acl_match_pkg.sv
// Purpose: Shared types and constants for the IPv4 access rule entry matcher
// Assumes: 32-bit AXI4-Lite register access, one switch core clock
// Notes:   Control word layout is carried by ctrl_t
package acl_match_pkg;

  localparam int          AXI_ADDR_W   = 8;
  localparam int          DATA_W       = 32;

  // Register byte offsets
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_SRC_ADDR = 8'h04;
  localparam logic [7:0]  OFS_SRC_MASK = 8'h08;
  localparam logic [7:0]  OFS_DST_ADDR = 8'h0c;
  localparam logic [7:0]  OFS_DST_MASK = 8'h10;
  localparam logic [7:0]  OFS_HIT_CNT  = 8'h14;

  // Reset values and control register write mask
  localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
  localparam logic [31:0] ADDR_RST     = 32'h0000_0000;
  localparam logic [31:0] MASK_RST     = 32'hffff_ffff;
  localparam logic [31:0] CTRL_WMASK   = 32'h93ff_ff07;

  localparam logic [7:0]  PROTO_ICMP   = 8'h01;
  localparam logic [7:0]  PROTO_TCP    = 8'h06;
  localparam logic [7:0]  PROTO_UDP    = 8'h11;

  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [2:0] {
    PSEL_ANY  = 3'h0,
    PSEL_SPEC = 3'h1,
    PSEL_ICMP = 3'h2,
    PSEL_UDP  = 3'h3,
    PSEL_TCP  = 3'h4
  } proto_sel_t;

  // For TTL: NO means zero, YES means non-zero
  typedef enum logic [1:0] {
    COND_ANY = 2'h0,
    COND_NO  = 2'h1,
    COND_YES = 2'h2
  } cond_t;

  typedef enum logic [1:0] {
    AM_ANY  = 2'h0,
    AM_HOST = 2'h1,
    AM_NET  = 2'h2
  } addr_mode_t;

  typedef struct packed {
    logic       enable;
    logic [1:0] rsv_a;
    logic       deny;
    logic [1:0] rsv_b;
    addr_mode_t dst_mode;
    addr_mode_t src_mode;
    cond_t      opt_cond;
    cond_t      frag_cond;
    cond_t      ttl_cond;
    logic [7:0] proto_val;
    logic [4:0] rsv_c;
    proto_sel_t proto_sel;
  } ctrl_t;

  typedef struct packed {
    logic        valid;
    logic        is_ipv4;
    logic [7:0]  proto;
    logic [7:0]  ttl;
    logic        more_frag;
    logic [12:0] frag_off;
    logic        has_opts;
    logic [31:0] src_ip;
    logic [31:0] dst_ip;
  } hdr_t;

  typedef struct packed {
    logic valid;
    logic hit;
    logic drop;
  } result_t;

endpackage

// file: hdl/ip_addr_filter.sv
// Purpose: One IPv4 address filter of an access rule entry
// Assumes: Purely combinational, evaluated inside the matcher's register stage
// Notes:   Undefined mode codes never hit, so a bad setting cannot open the entry
`timescale 1ns/100ps
module ip_addr_filter
  import acl_match_pkg::*;
(
  input  acl_match_pkg::addr_mode_t mode,
  input  wire logic [31:0]          cfg_addr,
  input  wire logic [31:0]          cfg_mask,
  input  wire logic [31:0]          frame_addr,
  output logic                      hit
);
  import acl_match_pkg::*;

  always_comb
  begin
    case (mode)
      AM_ANY:  hit = 1'b1;
      AM_HOST: hit = (frame_addr == cfg_addr);
      AM_NET:  hit = ((frame_addr & cfg_mask) == (cfg_addr & cfg_mask));
      default: hit = 1'b0;
    endcase
  end

endmodule

// file: hdl/ipv4_acl_entry_matcher.sv
// Purpose: Match logic of one IPv4 access rule entry with an AXI4-Lite register slave
// Assumes: Parsed header fields arrive from logic on aclk; ce low freezes every flip-flop
// Notes:   Result registered one cycle after the header; hit counter cleared by a write to OFS_HIT_CNT
`timescale 1ns/100ps
module ipv4_acl_entry_matcher
  import acl_match_pkg::*;
#(
  parameter int CNT_W = 32
)
(
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic                   ce,
  input  wire logic [AXI_ADDR_W-1:0]  s_awaddr,
  input  wire logic                   s_awvalid,
  output logic                        s_awready,
  input  wire logic [31:0]            s_wdata,
  input  wire logic [3:0]             s_wstrb,
  input  wire logic                   s_wvalid,
  output logic                        s_wready,
  output logic [1:0]                  s_bresp,
  output logic                        s_bvalid,
  input  wire logic                   s_bready,
  input  wire logic [AXI_ADDR_W-1:0]  s_araddr,
  input  wire logic                   s_arvalid,
  output logic                        s_arready,
  output logic [31:0]                 s_rdata,
  output logic [1:0]                  s_rresp,
  output logic                        s_rvalid,
  input  wire logic                   s_rready,
  input  acl_match_pkg::hdr_t         hdr,
  output acl_match_pkg::result_t      result
);
  import acl_match_pkg::*;

  if (CNT_W < 1 || CNT_W > DATA_W)
  begin : g_cnt_check
    $error("CNT_W must lie between 1 and 32");
  end

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        r[b*8 +: 8] = new_v[b*8 +: 8];
    end
    return r;
  endfunction

  ctrl_t                   ctrl_q;
  logic [31:0]             src_addr_q;
  logic [31:0]             src_mask_q;
  logic [31:0]             dst_addr_q;
  logic [31:0]             dst_mask_q;
  logic [CNT_W-1:0]        hit_cnt_q;
  logic [AXI_ADDR_W-1:0]   awaddr_q;
  logic                    aw_have_q;
  logic [31:0]             wdata_q;
  logic [3:0]              wstrb_q;
  logic                    w_have_q;
  logic                    bvalid_q;
  logic [1:0]              bresp_q;
  logic                    rvalid_q;
  logic [1:0]              rresp_q;
  logic [31:0]             rdata_q;
  logic [31:0]             rdata_d;
  logic                    rd_ok;
  logic                    wr_fire;
  logic                    wr_ok;
  logic                    proto_hit;
  logic                    ttl_hit;
  logic                    frag_hit;
  logic                    opt_hit;
  logic                    src_hit;
  logic                    dst_hit;
  logic                    fragmented;
  logic                    entry_hit;
  result_t                 result_q;

  // Write channel: address and data are caught separately, in either order
  assign s_awready = ce && !aw_have_q && !bvalid_q;
  assign s_wready  = ce && !w_have_q && !bvalid_q;
  assign wr_fire   = ce && aw_have_q && w_have_q && !bvalid_q;
  assign wr_ok     = (awaddr_q == OFS_CTRL) || (awaddr_q == OFS_SRC_ADDR) ||
                     (awaddr_q == OFS_SRC_MASK) || (awaddr_q == OFS_DST_ADDR) ||
                     (awaddr_q == OFS_DST_MASK) || (awaddr_q == OFS_HIT_CNT);
  assign s_bvalid  = bvalid_q;
  assign s_bresp   = bresp_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      awaddr_q  <= '0;
    end
    else if (ce)
    begin
      if (s_awvalid && s_awready)
      begin
        aw_have_q <= 1'b1;
        awaddr_q  <= {s_awaddr[AXI_ADDR_W-1:2], 2'b00};
      end
      else if (wr_fire)
        aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_have_q <= 1'b0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end
    else if (ce)
    begin
      if (s_wvalid && s_wready)
      begin
        w_have_q <= 1'b1;
        wdata_q  <= s_wdata;
        wstrb_q  <= s_wstrb;
      end
      else if (wr_fire)
        w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (wr_fire)
      begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_bready)
        bvalid_q <= 1'b0;
    end
  end

  // Configuration store; reserved control bits are never kept
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q     <= ctrl_t'(CTRL_RST);
      src_addr_q <= ADDR_RST;
      src_mask_q <= MASK_RST;
      dst_addr_q <= ADDR_RST;
      dst_mask_q <= MASK_RST;
    end
    else if (wr_fire)
    begin
      case (awaddr_q)
        OFS_CTRL:     ctrl_q     <= ctrl_t'(merge(ctrl_q, wdata_q, wstrb_q) & CTRL_WMASK);
        OFS_SRC_ADDR: src_addr_q <= merge(src_addr_q, wdata_q, wstrb_q);
        OFS_SRC_MASK: src_mask_q <= merge(src_mask_q, wdata_q, wstrb_q);
        OFS_DST_ADDR: dst_addr_q <= merge(dst_addr_q, wdata_q, wstrb_q);
        OFS_DST_MASK: dst_mask_q <= merge(dst_mask_q, wdata_q, wstrb_q);
        default:      ;
      endcase
    end
  end

  // Read channel: one outstanding read, data registered
  assign s_arready = ce && !rvalid_q;
  assign s_rvalid  = rvalid_q;
  assign s_rdata   = rdata_q;
  assign s_rresp   = rresp_q;

  always_comb
  begin
    rd_ok   = 1'b1;
    rdata_d = '0;
    case ({s_araddr[AXI_ADDR_W-1:2], 2'b00})
      OFS_CTRL:     rdata_d = 32'(ctrl_q);
      OFS_SRC_ADDR: rdata_d = src_addr_q;
      OFS_SRC_MASK: rdata_d = src_mask_q;
      OFS_DST_ADDR: rdata_d = dst_addr_q;
      OFS_DST_MASK: rdata_d = dst_mask_q;
      OFS_HIT_CNT:  rdata_d = 32'(hit_cnt_q);
      default:      rd_ok   = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_arvalid && s_arready)
      begin
        rvalid_q <= 1'b1;
        rdata_q  <= rdata_d;
        rresp_q  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_rready)
        rvalid_q <= 1'b0;
    end
  end

  // Match conditions
  always_comb
  begin
    case (ctrl_q.proto_sel)
      PSEL_ANY:  proto_hit = 1'b1;
      PSEL_SPEC: proto_hit = (hdr.proto == ctrl_q.proto_val);
      PSEL_ICMP: proto_hit = (hdr.proto == PROTO_ICMP);
      PSEL_UDP:  proto_hit = (hdr.proto == PROTO_UDP);
      PSEL_TCP:  proto_hit = (hdr.proto == PROTO_TCP);
      default:   proto_hit = 1'b0;
    endcase
  end

  always_comb
  begin
    case (ctrl_q.ttl_cond)
      COND_ANY: ttl_hit = 1'b1;
      COND_NO:  ttl_hit = (hdr.ttl == 8'h00);
      COND_YES: ttl_hit = (hdr.ttl != 8'h00);
      default:  ttl_hit = 1'b0;
    endcase
  end

  assign fragmented = hdr.more_frag || (hdr.frag_off != 13'h0000);

  always_comb
  begin
    case (ctrl_q.frag_cond)
      COND_ANY: frag_hit = 1'b1;
      COND_NO:  frag_hit = !fragmented;
      COND_YES: frag_hit = fragmented;
      default:  frag_hit = 1'b0;
    endcase
  end

  always_comb
  begin
    case (ctrl_q.opt_cond)
      COND_ANY: opt_hit = 1'b1;
      COND_NO:  opt_hit = !hdr.has_opts;
      COND_YES: opt_hit = hdr.has_opts;
      default:  opt_hit = 1'b0;
    endcase
  end

  ip_addr_filter u_src_filter (
    .mode       (ctrl_q.src_mode),
    .cfg_addr   (src_addr_q),
    .cfg_mask   (src_mask_q),
    .frame_addr (hdr.src_ip),
    .hit        (src_hit)
  );

  ip_addr_filter u_dst_filter (
    .mode       (ctrl_q.dst_mode),
    .cfg_addr   (dst_addr_q),
    .cfg_mask   (dst_mask_q),
    .frame_addr (hdr.dst_ip),
    .hit        (dst_hit)
  );

  assign entry_hit = ctrl_q.enable && hdr.is_ipv4 &&
                     proto_hit && ttl_hit && frag_hit && opt_hit &&
                     src_hit && dst_hit;

  // One register stage between header and verdict
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      result_q <= '0;
    else if (ce)
    begin
      result_q.valid <= hdr.valid;
      result_q.hit   <= hdr.valid && entry_hit;
      result_q.drop  <= hdr.valid && entry_hit && ctrl_q.deny;
    end
  end

  assign result = result_q;

  // Hit counter; a hit in the clearing cycle still counts
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      hit_cnt_q <= '0;
    else if (ce)
    begin
      if (wr_fire && awaddr_q == OFS_HIT_CNT)
        hit_cnt_q <= CNT_W'(result_q.valid && result_q.hit);
      else if (result_q.valid && result_q.hit)
        hit_cnt_q <= hit_cnt_q + 1'b1;
    end
  end

  AST_LATENCY: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && hdr.valid |=> result.valid)
    else $error("Result not valid one clock after header");

  AST_NOT_IPV4: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && hdr.valid && !hdr.is_ipv4 |=> !result.hit)
    else $error("Non-IPv4 frame matched");

  AST_PROTO_SPEC: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && hdr.valid && ctrl_q.proto_sel == PSEL_SPEC && hdr.proto != ctrl_q.proto_val |=> !result.hit)
    else $error("Protocol value mismatch matched");

  AST_PROTO_NAMED: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && hdr.valid && ((ctrl_q.proto_sel == PSEL_ICMP && hdr.proto != PROTO_ICMP) ||
    (ctrl_q.proto_sel == PSEL_UDP && hdr.proto != PROTO_UDP) ||
    (ctrl_q.proto_sel == PSEL_TCP && hdr.proto != PROTO_TCP)) |=> !result.hit)
    else $error("Wrong named protocol matched");

  AST_TTL: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && hdr.valid && ((ctrl_q.ttl_cond == COND_NO && hdr.ttl != 8'h00) ||
    (ctrl_q.ttl_cond == COND_YES && hdr.ttl == 8'h00)) |=> !result.hit)
    else $error("TTL condition violated");

  AST_FRAG: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && hdr.valid && ((ctrl_q.frag_cond == COND_NO && fragmented) ||
    (ctrl_q.frag_cond == COND_YES && !hdr.more_frag && hdr.frag_off == 13'h0000)) |=> !result.hit)
    else $error("Fragment condition violated");

  AST_OPT: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && hdr.valid && ((ctrl_q.opt_cond == COND_NO && hdr.has_opts) ||
    (ctrl_q.opt_cond == COND_YES && !hdr.has_opts)) |=> !result.hit)
    else $error("Options condition violated");

  AST_SRC_ADDR: assert property (@(posedge aclk) disable iff (!aresetn)
    ((ctrl_q.src_mode == AM_HOST && hdr.src_ip != src_addr_q) ||
    (ctrl_q.src_mode == AM_NET && ((hdr.src_ip ^ src_addr_q) & src_mask_q) != 32'h0000_0000)) |-> !src_hit)
    else $error("Source address filter passed a mismatch");

  AST_DST_ADDR: assert property (@(posedge aclk) disable iff (!aresetn)
    ((ctrl_q.dst_mode == AM_HOST && hdr.dst_ip != dst_addr_q) ||
    (ctrl_q.dst_mode == AM_NET && ((hdr.dst_ip ^ dst_addr_q) & dst_mask_q) != 32'h0000_0000)) |-> !dst_hit)
    else $error("Destination address filter passed a mismatch");

  AST_ALL_ANY: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && hdr.valid && hdr.is_ipv4 && 32'(ctrl_q) == 32'h8000_0000 |=> result.hit)
    else $error("Fully open IPv4 entry did not match");

  AST_DROP: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && hdr.valid |=> result.drop == (result.hit && $past(ctrl_q.deny)))
    else $error("Drop does not follow hit and action");

  COV_DENY_HIT:  cover property (@(posedge aclk) disable iff (!aresetn) result.valid && result.drop);
  COV_PERMIT:    cover property (@(posedge aclk) disable iff (!aresetn) result.valid && result.hit && !result.drop);
  COV_NET_MATCH: cover property (@(posedge aclk) disable iff (!aresetn)
    ce && hdr.valid && ctrl_q.src_mode == AM_NET && ctrl_q.dst_mode == AM_NET ##1 result.hit);

endmodule

// file: sim/parser_model.sv
// Purpose: Frame parser stand-in presenting parsed IPv4 header fields to the matcher
// Assumes: Each header launched just after a rising edge of aclk
// Notes:   On release the fields are inverted and valid cleared so stale values never look like a header
`timescale 1ns/100ps
module parser_model
(
  input  wire logic           aclk,
  output acl_match_pkg::hdr_t hdr
);
  import acl_match_pkg::*;

  initial hdr = '0;

  task automatic send(input hdr_t h);
    @(posedge aclk);
    hdr <= h;
  endtask

  task automatic release_bus();
    hdr_t t;
    t = ~hdr;
    t.valid = 1'b0;
    @(posedge aclk);
    hdr <= t;
  endtask
endmodule

// file: sim/ipv4_acl_entry_matcher_bench.sv
// Purpose: Self-checking bench for the IPv4 access rule entry matcher
// Assumes: ce tied high; registers reached over AXI4-Lite
// Notes:   Random entry settings and biased headers so hits and misses both occur often
`timescale 1ns/100ps
module ipv4_acl_entry_matcher_bench;
  import acl_match_pkg::*;

  typedef struct {result_t r; int cyc;} note_t;

  logic                  aclk = 1'b0;
  logic                  aresetn = 1'b0;
  logic [7:0]            s_awaddr = '0, s_araddr = '0;
  logic                  s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic [31:0]           s_wdata = '0;
  logic [3:0]            s_wstrb = '0;
  logic                  s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0]            s_bresp, s_rresp;
  logic [31:0]           s_rdata;
  hdr_t                  hdr;
  result_t               result;
  logic [31:0]           seed = 32'd89367;
  int                    n_errors = 0, checks_done = 0, cyc = 0, k;
  note_t                 q[$];

  ipv4_acl_entry_matcher i_ipv4_acl_entry_matcher (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
    .s_rvalid(s_rvalid), .s_rready(s_rready), .hdr(hdr), .result(result));
  parser_model i_parser_model (.aclk(aclk), .hdr(hdr));

  initial
  begin
    forever #5 aclk = ~aclk;
  end

  always @(posedge aclk) cyc <= cyc + 1;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Both channels offered together; the answer is taken at the edge where bvalid is sampled high.
  // bready and rready stay high between transfers, so back-to-back calls never drive one signal twice
  // in a time step, and the loop always lets an edge pass before it looks at the answer.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    int n;
    s_awaddr <= a; s_awvalid <= 1'b1; s_wdata <= d; s_wstrb <= s; s_wvalid <= 1'b1; s_bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
      n++;
    end
    while (s_bvalid !== 1'b1 && n < 64);
    if (s_bvalid !== 1'b1) n_errors++;
    chk(s_bresp, er);
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    s_araddr <= a; s_arvalid <= 1'b1; s_rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
      n++;
    end
    while (s_rvalid !== 1'b1 && n < 64);
    if (s_rvalid !== 1'b1) n_errors++;
    chk(s_rdata, ed);
    chk(s_rresp, er);
  endtask

  function automatic logic cnd(input cond_t c, input logic x);
    case (c)
      COND_ANY: return 1'b1;
      COND_NO:  return !x;
      COND_YES: return x;
      default:  return 1'b0;
    endcase
  endfunction

  function automatic logic am(input addr_mode_t m, input logic [31:0] a, msk, f);
    case (m)
      AM_ANY:  return 1'b1;
      AM_HOST: return a == f;
      AM_NET:  return ((a ^ f) & msk) == 0;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic exp_hit(input ctrl_t c, input logic [31:0] sa, sm, da, dm, input hdr_t h);
    logic p;
    case (c.proto_sel)
      PSEL_ANY:  p = 1'b1;
      PSEL_SPEC: p = h.proto == c.proto_val;
      PSEL_ICMP: p = h.proto == PROTO_ICMP;
      PSEL_UDP:  p = h.proto == PROTO_UDP;
      PSEL_TCP:  p = h.proto == PROTO_TCP;
      default:   p = 1'b0;
    endcase
    return h.valid && h.is_ipv4 && c.enable && p && cnd(c.ttl_cond, h.ttl != 0)
      && cnd(c.frag_cond, h.more_frag || h.frag_off != 0) && cnd(c.opt_cond, h.has_opts)
      && am(c.src_mode, sa, sm, h.src_ip) && am(c.dst_mode, da, dm, h.dst_ip);
  endfunction

  // Code 3 kept rare so that most entries can still hit
  function automatic logic [1:0] f3(input logic [1:0] x, input logic raw);
    return raw ? x : x % 3;
  endfunction

  task automatic round();
    ctrl_t       c;
    hdr_t        h;
    note_t       n;
    logic [31:0] r, sa, sm, da, dm, hits;
    logic        e, raw;
    int          j;
    r = rnd();
    raw = r[27:26] == 2'h0;
    c = '0;
    c.proto_sel = proto_sel_t'(3'(r[7:0] % 6));
    c.proto_val = r[15:8];
    c.ttl_cond = cond_t'(f3(r[17:16], raw));
    c.frag_cond = cond_t'(f3(r[19:18], raw));
    c.opt_cond = cond_t'(f3(r[21:20], raw));
    c.src_mode = addr_mode_t'(f3(r[23:22], raw));
    c.dst_mode = addr_mode_t'(f3(r[25:24], raw));
    c.deny = r[28];
    c.enable = r[31] | r[30];
    // First round uses a fully open permit entry so every IPv4 header must hit
    if (k == 0) c = ctrl_t'(32'h8000_0000);
    sa = rnd(); da = rnd();
    sm = 32'hffff_ffff << (rnd() % 33);
    dm = 32'hffff_ffff << (rnd() % 33);
    axi_wr(OFS_CTRL, c, 4'hf, RESP_OKAY);
    axi_wr(OFS_SRC_ADDR, sa, 4'hf, RESP_OKAY);
    axi_wr(OFS_SRC_MASK, sm, 4'hf, RESP_OKAY);
    axi_wr(OFS_DST_ADDR, da, 4'hf, RESP_OKAY);
    axi_wr(OFS_DST_MASK, dm, 4'hf, RESP_OKAY);
    axi_wr(OFS_HIT_CNT, 32'h0000_0000, 4'hf, RESP_OKAY);
    hits = '0;
    for (j = 0; j < 16; j++)
    begin
      r = rnd();
      h.valid = r[2:0] != 3'h0;
      h.is_ipv4 = r[5:3] != 3'h0;
      case (r[8:6])
        3'h0: h.proto = PROTO_ICMP;
        3'h1: h.proto = PROTO_TCP;
        3'h2: h.proto = PROTO_UDP;
        3'h3, 3'h4: h.proto = c.proto_val;
        default: h.proto = r[31:24];
      endcase
      h.ttl = (r[10:9] == 2'h0) ? 8'h00 : (r[10:9] == 2'h1) ? 8'h01 : r[23:16];
      h.more_frag = r[11] & r[12];
      h.frag_off = r[13] ? 13'(r[31:20]) : 13'h0000;
      h.has_opts = r[14];
      h.src_ip = r[15] ? sa ^ (rnd() & ~sm) : rnd();
      h.dst_ip = r[16] ? da ^ (rnd() & ~dm) : rnd();
      e = exp_hit(c, sa, sm, da, dm, h);
      i_parser_model.send(h);
      n.r = '{valid: 1'b1, hit: e, drop: e & c.deny};
      n.cyc = cyc + 2;
      if (h.valid) q.push_back(n);
      hits += 32'(e);
    end
    i_parser_model.release_bus();
    repeat (2) @(posedge aclk);
    axi_rd(OFS_HIT_CNT, hits, RESP_OKAY);
  endtask

  initial
  begin
    note_t n;
    forever
    begin
      @(posedge aclk);
      #1;
      if (result.valid === 1'b1)
      begin
        chk(32'(q.size() != 0), 32'h1);
        if (q.size() != 0)
        begin
          n = q.pop_front();
          chk({29'h0, result}, {29'h0, n.r});
          chk({29'h0, result}, {29'h0, n.r});
          chk({29'h0, result}, {29'h0, n.r});
          chk(32'(cyc), 32'(n.cyc));
        end
      end
      else if (aresetn === 1'b1)
        chk({30'h0, result.hit, result.drop}, 32'h0);
    end
  end

  initial
  begin
    #300000;
    n_errors++;
    end_sim();
  end

  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(OFS_CTRL, CTRL_RST, RESP_OKAY);
    axi_rd(OFS_SRC_ADDR, ADDR_RST, RESP_OKAY);
    axi_rd(OFS_SRC_MASK, MASK_RST, RESP_OKAY);
    axi_rd(OFS_DST_ADDR, ADDR_RST, RESP_OKAY);
    axi_rd(OFS_DST_MASK, MASK_RST, RESP_OKAY);
    axi_rd(OFS_HIT_CNT, 32'h0000_0000, RESP_OKAY);
    axi_rd(8'h18, 32'h0000_0000, RESP_SLVERR);
    axi_wr(8'h18, 32'hffff_ffff, 4'hf, RESP_SLVERR);
    axi_wr(OFS_CTRL, 32'hffff_ffff, 4'h1, RESP_OKAY);
    axi_rd(OFS_CTRL, 32'h0000_0007, RESP_OKAY);
    axi_wr(OFS_CTRL, 32'hffff_ffff, 4'hf, RESP_OKAY);
    axi_rd(OFS_CTRL, CTRL_WMASK, RESP_OKAY);
    axi_wr(OFS_SRC_MASK, 32'h8000_0001, 4'hf, RESP_OKAY);
    axi_rd(OFS_SRC_MASK, 32'h8000_0001, RESP_OKAY);
    for (k = 0; k < 40; k++) round();
    repeat (4) @(posedge aclk);
    chk(32'(q.size()), 32'h0);
    end_sim();
  end
endmodule
